// [hdl/pwmsd_pkg.sv]
package pwmsd_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int         ADDR_W        = 2;
   localparam logic [1:0] SHDN_CTRL_OFF = 2'h0;
   localparam logic [1:0] RST_DB_OFF    = 2'h1;
   localparam logic [1:0] EVT_STAT_OFF  = 2'h2;
   localparam logic [1:0] EVT_MASK_OFF  = 2'h3;
   localparam logic [7:0] SHDN_CTRL_RST = 8'h00;
   localparam logic [7:0] RST_DB_RST    = 8'h00;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int STATUS_BIT   = 7;
   localparam int IRQ_SEL_BIT  = 6;
   localparam int PORT_SEL_BIT = 4;
   localparam int PSS_AC_LSB   = 2;
   localparam int PSS_BD_LSB   = 0;
   localparam int AUTO_RST_BIT = 7;
   localparam int DB_COUNT_W   = 7;

   // Event bits in the status and mask registers.
   localparam int EV_SHUT_BIT    = 0;
   localparam int EV_RESTART_BIT = 1;
   localparam int EV_W           = 2;

   // ------------------------------------------------------------------
   // Safe state codes and timing
   // ------------------------------------------------------------------
   localparam logic [1:0] SAFE_LOW  = 2'h0;
   localparam logic [1:0] SAFE_HIGH = 2'h1;
   localparam int         TOSC_NS      = 10;
   localparam int         TOSC_PER_INSTR = 4;
   localparam int         INSTR_NS       = TOSC_NS * TOSC_PER_INSTR;
   localparam int         INSTR_CYCLES   = INSTR_NS / TOSC_NS;

endpackage : pwmsd_pkg

// [hdl/pwmsd_deadband.sv]
`timescale 1ns/1ps
module pwmsd_deadband #(
   parameter int CNT_W = 7
) (
   input  wire logic             sys_clk,   // System clock.
   input  wire logic             rst_n,     // Async reset, active low.
   input  wire logic             enable,    // Half-bridge delay enable.
   input  wire logic             tick,      // One instruction cycle pulse.
   input  wire logic [CNT_W-1:0] count,     // Delay in instruction cycles.
   input  wire logic             in_level,  // Undelayed drive, active high.
   output logic                  out_level  // Delayed drive.
);

   logic [CNT_W-1:0] elapsed;
   logic             next_out;

   // ------------------------------------------------------------------
   // Delay counter
   // ------------------------------------------------------------------
   // Counting restarts whenever the drive is inactive, so a short pulse
   // shorter than the dead band never reaches the pin.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         elapsed <= '0;
      end else if (!in_level) begin
         elapsed <= '0;
      end else if (tick && elapsed < count) begin
         elapsed <= elapsed + 1'b1;
      end
   end

   // Comparing with >= keeps a count lowered in mid-pulse from stalling the pin.
   assign next_out = in_level && (!enable || elapsed >= count);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_level <= 1'b0;
      end else begin
         out_level <= next_out;
      end
   end

   chk_fall_no_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !in_level |=> !out_level) else $error("falling edge was delayed");
   chk_zero_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
      in_level && count == '0 |=> out_level) else $error("zero count added delay");
   chk_rise_waits: assert property (@(posedge sys_clk) disable iff (!rst_n)
      enable && $rose(in_level) && count != '0 |=> !out_level)
      else $error("rising edge not delayed");
   cov_delayed_rise: cover property (@(posedge sys_clk) disable iff (!rst_n)
      enable && count > 1 && $rose(out_level));

endmodule : pwmsd_deadband

// [hdl/pwmsd_top.sv]
`timescale 1ns/1ps
module pwmsd_top #(
   parameter int DB_W = pwmsd_pkg::DB_COUNT_W
) (
   input  wire logic                        sys_clk,      // 100 MHz clock.
   input  wire logic                        rst_n,        // Async reset.
   input  wire logic [pwmsd_pkg::ADDR_W-1:0] reg_addr,    // Register index.
   input  wire logic [7:0]                  reg_wdata,    // Write data.
   input  wire logic                        reg_wr,       // Write strobe.
   input  wire logic                        reg_rd,       // Read strobe.
   output logic      [7:0]                  reg_rdata,    // Read data.
   input  wire logic                        half_bridge,  // Half-bridge mode.
   input  wire logic                        period_start, // Period start pulse.
   input  wire logic                        pwm_a,        // Raw drive A/C.
   input  wire logic                        pwm_b,        // Raw drive B/D.
   input  wire logic                        int_pin_n,    // Interrupt pin.
   input  wire logic                        port_b_pin4,  // Port pin source.
   output logic                             out_a,        // Pin A level.
   output logic                             out_a_oe,     // Pin A enable.
   output logic                             out_b,        // Pin B level.
   output logic                             out_b_oe,     // Pin B enable.
   output logic                             out_c,        // Pin C level.
   output logic                             out_c_oe,     // Pin C enable.
   output logic                             out_d,        // Pin D level.
   output logic                             out_d_oe,     // Pin D enable.
   output logic                             irq           // Event interrupt.
);

   if (DB_W != pwmsd_pkg::DB_COUNT_W) begin : g_bad_width
      $error("dead-band count width must match the control field");
   end

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic                     shutdown_status;
   logic                     irq_pin_shutdown_select;
   logic                     port_pin_shutdown_select;
   logic [1:0]               pair_ac_safe_state;
   logic [1:0]               pair_bd_safe_state;
   logic                     auto_restart_enable;
   logic [DB_W-1:0]          deadband_count;
   logic [pwmsd_pkg::EV_W-1:0] ev_status;
   logic [pwmsd_pkg::EV_W-1:0] ev_mask;

   logic shut_cond;
   logic resume_wait;
   logic shut_active;
   logic status_prev;
   logic wr_shdn;
   logic instruction_cycle;
   logic [1:0] tcy_div;
   logic drv_a;
   logic drv_b;
   logic [pwmsd_pkg::EV_W-1:0] ev_set;

   function automatic logic hits(input logic [pwmsd_pkg::ADDR_W-1:0] a,
                                 input logic [pwmsd_pkg::ADDR_W-1:0] off);
      hits = (a == off);
   endfunction : hits

   // ------------------------------------------------------------------
   // Safe state decode
   // ------------------------------------------------------------------
   // Both pin pairs share one code table, so the decode lives here once.
   function automatic logic safe_level(input logic [1:0] code);
      safe_level = (code == pwmsd_pkg::SAFE_HIGH);
   endfunction : safe_level

   function automatic logic safe_oe(input logic [1:0] code);
      safe_oe = !code[1];
   endfunction : safe_oe

   assign wr_shdn = reg_wr && hits(reg_addr, pwmsd_pkg::SHDN_CTRL_OFF);

   // ------------------------------------------------------------------
   // Shutdown condition
   // ------------------------------------------------------------------
   // Pure level from the pins, no flop, so the pins react at once.
   assign shut_cond = (irq_pin_shutdown_select && !int_pin_n)
                    || (port_pin_shutdown_select && !port_b_pin4);

   // ------------------------------------------------------------------
   // Instruction cycle divider
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tcy_div <= 2'h0;
      end else begin
         tcy_div <= tcy_div + 2'h1;
      end
   end

   // The divider runs free, so the first tick after a rising drive comes one
   // to four cycles later and a dead band may run up to three cycles short.
   assign instruction_cycle = (tcy_div == 2'(pwmsd_pkg::INSTR_CYCLES - 1));

   // ------------------------------------------------------------------
   // Shutdown control register
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_pin_shutdown_select  <= 1'b0;
         port_pin_shutdown_select <= 1'b0;
         pair_ac_safe_state       <= pwmsd_pkg::SHDN_CTRL_RST[3:2];
         pair_bd_safe_state       <= pwmsd_pkg::SHDN_CTRL_RST[1:0];
      end else if (wr_shdn) begin
         irq_pin_shutdown_select  <= reg_wdata[pwmsd_pkg::IRQ_SEL_BIT];
         port_pin_shutdown_select <= reg_wdata[pwmsd_pkg::PORT_SEL_BIT];
         pair_ac_safe_state       <= reg_wdata[pwmsd_pkg::PSS_AC_LSB +: 2];
         pair_bd_safe_state       <= reg_wdata[pwmsd_pkg::PSS_BD_LSB +: 2];
      end
   end

   // A live condition sets the bit every cycle, which both holds it and
   // makes any software write to it a no-op.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         shutdown_status <= 1'b0;
      end else if (shut_cond) begin
         shutdown_status <= 1'b1;
      end else if (wr_shdn) begin
         shutdown_status <= reg_wdata[pwmsd_pkg::STATUS_BIT];
      end else if (auto_restart_enable) begin
         shutdown_status <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Restart and dead-band control register
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         auto_restart_enable <= pwmsd_pkg::RST_DB_RST[pwmsd_pkg::AUTO_RST_BIT];
         deadband_count      <= pwmsd_pkg::RST_DB_RST[DB_W-1:0];
      end else if (reg_wr && hits(reg_addr, pwmsd_pkg::RST_DB_OFF)) begin
         auto_restart_enable <= reg_wdata[pwmsd_pkg::AUTO_RST_BIT];
         deadband_count      <= reg_wdata[DB_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // Restart alignment
   // ------------------------------------------------------------------
   // Outputs stay safe after the status bit drops until a period begins,
   // so the first pulse after a restart is never a truncated one.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         resume_wait <= 1'b0;
      end else if (shutdown_status || shut_cond) begin
         resume_wait <= 1'b1;
      end else if (period_start) begin
         resume_wait <= 1'b0;
      end
   end

   assign shut_active = shut_cond || shutdown_status || resume_wait;

   // ------------------------------------------------------------------
   // Dead band and output stage
   // ------------------------------------------------------------------
   for (genvar i = 0; i < 2; i++) begin : g_db
      logic raw;
      logic dly;
      assign raw = (i == 0) ? pwm_a : pwm_b;
      pwmsd_deadband #(.CNT_W(DB_W)) u_db (
         .sys_clk   (sys_clk),
         .rst_n     (rst_n),
         .enable    (half_bridge),
         .tick      (instruction_cycle),
         .count     (deadband_count),
         .in_level  (raw),
         .out_level (dly)
      );
   end

   assign drv_a = g_db[0].dly;
   assign drv_b = g_db[1].dly;

   // Pin pair A/C shares one safe state, pair B/D the other.
   // C and D only mirror A and B here; full-bridge steering is not built.
   always_comb begin
      out_a    = drv_a;
      out_c    = drv_a;
      out_b    = drv_b;
      out_d    = drv_b;
      out_a_oe = 1'b1;
      out_c_oe = 1'b1;
      out_b_oe = 1'b1;
      out_d_oe = 1'b1;
      if (shut_active) begin
         out_a    = safe_level(pair_ac_safe_state);
         out_c    = safe_level(pair_ac_safe_state);
         out_a_oe = safe_oe(pair_ac_safe_state);
         out_c_oe = safe_oe(pair_ac_safe_state);
         out_b    = safe_level(pair_bd_safe_state);
         out_d    = safe_level(pair_bd_safe_state);
         out_b_oe = safe_oe(pair_bd_safe_state);
         out_d_oe = safe_oe(pair_bd_safe_state);
      end
   end

   // ------------------------------------------------------------------
   // Event flags and interrupt
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_prev <= 1'b0;
      end else begin
         status_prev <= shutdown_status;
      end
   end

   assign ev_set[pwmsd_pkg::EV_SHUT_BIT]    = shutdown_status && !status_prev;
   assign ev_set[pwmsd_pkg::EV_RESTART_BIT] = resume_wait && period_start &&
                                              !shutdown_status && !shut_cond;

   // Set wins over a write-one clear in the same cycle.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_status <= '0;
      end else if (reg_wr && hits(reg_addr, pwmsd_pkg::EVT_STAT_OFF)) begin
         ev_status <= (ev_status & ~reg_wdata[pwmsd_pkg::EV_W-1:0]) | ev_set;
      end else begin
         ev_status <= ev_status | ev_set;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_mask <= '0;
      end else if (reg_wr && hits(reg_addr, pwmsd_pkg::EVT_MASK_OFF)) begin
         ev_mask <= reg_wdata[pwmsd_pkg::EV_W-1:0];
      end
   end

   assign irq = |(ev_status & ev_mask);

   // ------------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------------
   // Read data is zero except in the cycle after a read strobe, so a stale value is never
   // mistaken for fresh data.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else if (hits(reg_addr, pwmsd_pkg::SHDN_CTRL_OFF)) begin
         reg_rdata <= {shutdown_status, irq_pin_shutdown_select, 1'b0,
                       port_pin_shutdown_select, pair_ac_safe_state,
                       pair_bd_safe_state};
      end else if (hits(reg_addr, pwmsd_pkg::RST_DB_OFF)) begin
         reg_rdata <= {auto_restart_enable, deadband_count};
      end else if (hits(reg_addr, pwmsd_pkg::EVT_STAT_OFF)) begin
         reg_rdata <= {6'h00, ev_status};
      end else begin
         reg_rdata <= {6'h00, ev_mask};
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_safe_low_ac: assert property (@(posedge sys_clk) disable iff (!rst_n)
      shut_active && pair_ac_safe_state == 2'h0 |-> out_a_oe && !out_a && !out_c)
      else $error("pair A/C not driven low");
   chk_tristate_bd: assert property (@(posedge sys_clk) disable iff (!rst_n)
      shut_active && pair_bd_safe_state[1] |-> !out_b_oe && !out_d_oe)
      else $error("pair B/D not released");
   chk_async_force: assert property (@(posedge sys_clk) disable iff (!rst_n)
      shut_cond |-> shut_active && out_a_oe == !pair_ac_safe_state[1] &&
                    out_b_oe == !pair_bd_safe_state[1])
      else $error("condition did not force pins");
   chk_level_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
      shut_cond ##1 shut_cond |-> shutdown_status) else $error("status dropped under level");
   chk_write_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
      shut_cond && wr_shdn && !reg_wdata[7] |=> shutdown_status)
      else $error("status cleared while condition held");
   chk_auto_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      auto_restart_enable && shutdown_status && !shut_cond && !wr_shdn |=> !shutdown_status)
      else $error("auto-restart did not clear status");
   chk_manual_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !auto_restart_enable && shutdown_status && !wr_shdn |=> shutdown_status)
      else $error("status cleared without software");
   chk_period_resume: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $fell(shut_active) |-> $past(period_start)) else $error("resumed mid period");
   chk_sw_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_shdn && reg_wdata[7] |=> shutdown_status ##0 shut_active)
      else $error("software shutdown ignored");
   chk_port_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !port_pin_shutdown_select && !irq_pin_shutdown_select |-> !shut_cond)
      else $error("unselected source acted");

   // The codes of both pairs not checked above, so a swapped pair or code shows up at once.
   chk_tristate_ac: assert property (@(posedge sys_clk) disable iff (!rst_n)
      shut_active && pair_ac_safe_state[1] |-> !out_a_oe && !out_c_oe)
      else $error("pair A/C not released");
   chk_safe_high_ac: assert property (@(posedge sys_clk) disable iff (!rst_n)
      shut_active && pair_ac_safe_state == pwmsd_pkg::SAFE_HIGH |-> out_a_oe && out_a && out_c)
      else $error("pair A/C not driven high");
   chk_safe_high_bd: assert property (@(posedge sys_clk) disable iff (!rst_n)
      shut_active && pair_bd_safe_state == pwmsd_pkg::SAFE_HIGH |-> out_b_oe && out_b && out_d)
      else $error("pair B/D not driven high");
   chk_safe_low_bd: assert property (@(posedge sys_clk) disable iff (!rst_n)
      shut_active && pair_bd_safe_state == pwmsd_pkg::SAFE_LOW |-> out_b_oe && !out_b && !out_d)
      else $error("pair B/D not driven low");

   // Status, restart and event flags, then tick spacing, shutdown sources and normal drive.
   chk_auto_stays: assert property (@(posedge sys_clk) disable iff (!rst_n)
      auto_restart_enable && shut_cond |=> shutdown_status)
      else $error("status dropped under auto-restart");
   chk_sw_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !shut_cond && wr_shdn && !reg_wdata[pwmsd_pkg::STATUS_BIT] |=> !shutdown_status)
      else $error("software clear ignored");
   chk_hold_no_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
      shut_active && !period_start |=> shut_active)
      else $error("pins released between periods");
   chk_wait_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
      shutdown_status |=> resume_wait) else $error("restart wait not armed");
   chk_restart_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $fell(shut_active) |-> ev_status[pwmsd_pkg::EV_RESTART_BIT])
      else $error("restart event not flagged");
   chk_shut_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(shutdown_status) |=> ev_status[pwmsd_pkg::EV_SHUT_BIT])
      else $error("shutdown event not flagged");
   chk_tick_spacing: assert property (@(posedge sys_clk) disable iff (!rst_n)
      instruction_cycle |=> (!instruction_cycle) [*3] ##1 instruction_cycle)
      else $error("instruction cycle tick off");
   chk_irq_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
      irq_pin_shutdown_select && !int_pin_n |-> shut_cond) else $error("pin source ignored");
   chk_port_acts: assert property (@(posedge sys_clk) disable iff (!rst_n)
      port_pin_shutdown_select && !port_b_pin4 |-> shut_cond) else $error("port source ignored");
   chk_normal_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !shut_active |-> out_a_oe && out_b_oe && out_c_oe && out_d_oe)
      else $error("pin enable low in normal run");

   cov_auto_restart: cover property (@(posedge sys_clk) disable iff (!rst_n)
      auto_restart_enable && $fell(shutdown_status));
   cov_sw_shutdown: cover property (@(posedge sys_clk) disable iff (!rst_n)
      wr_shdn && reg_wdata[7] && !shut_cond);
   cov_resume: cover property (@(posedge sys_clk) disable iff (!rst_n)
      $fell(shut_active));
   cov_tristate: cover property (@(posedge sys_clk) disable iff (!rst_n)
      shut_cond && !out_a_oe);

endmodule : pwmsd_top

// [verif/pwmsd_far_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Gate drivers and shutdown sense pins
// ----------------------------------------------------------------
module pwmsd_far_model (
   input  wire logic       int_low_req,  // Fault pulls int pin low.
   input  wire logic       port_low_req, // Fault pulls port pin low.
   input  wire logic [3:0] pin_lvl,      // Pin levels a, c, b, d.
   input  wire logic [3:0] pin_oe,       // Pin enables a, c, b, d.
   output logic            int_pin_n,    // Interrupt sense pin.
   output logic            port_b_pin4,  // Port sense pin.
   output logic      [3:0] gate          // Levels seen by the gates.
);
   // Both sense lines rest on pull-ups and only a fault drags them low.
   assign int_pin_n   = ~int_low_req;
   assign port_b_pin4 = ~port_low_req;
   // A released pin sits on the gate pull-down, so the switch stays off.
   assign gate = pin_lvl & pin_oe;
endmodule : pwmsd_far_model

// [verif/pwmsd_top_tb_top.sv]
`timescale 1ns/1ps
module pwmsd_top_tb_top;
   logic       sys_clk, rst_n, reg_wr, reg_rd, half_bridge, period_start;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic       pwm_a, pwm_b, int_pin_n, port_b_pin4, irq, int_req, port_req;
   logic       out_a, out_a_oe, out_b, out_b_oe, out_c, out_c_oe, out_d, out_d_oe;
   logic [3:0] gate;
   int         n_mismatch = 0;
   int         cmp_count = 0;

   pwmsd_top #(.DB_W(pwmsd_pkg::DB_COUNT_W)) dut_u (.sys_clk, .rst_n, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .half_bridge, .period_start,
      .pwm_a, .pwm_b, .int_pin_n, .port_b_pin4, .out_a, .out_a_oe, .out_b,
      .out_b_oe, .out_c, .out_c_oe, .out_d, .out_d_oe, .irq);
   pwmsd_far_model far_u (.int_low_req(int_req), .port_low_req(port_req),
      .pin_lvl({out_a, out_c, out_b, out_d}),
      .pin_oe({out_a_oe, out_c_oe, out_b_oe, out_d_oe}),
      .int_pin_n, .port_b_pin4, .gate);

   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd

   task automatic pulse;
      @(posedge sys_clk);
      period_start <= 1'b1;
      @(posedge sys_clk);
      period_start <= 1'b0;
      #1;
   endtask : pulse

   task automatic irqc(input logic [7:0] m, input logic e);
      wr(2'h3, m);
      #1 chk({7'h00, irq}, {7'h00, e});
   endtask : irqc

   // Enables of a, c, b, d above the gate levels; a tri-stated pin reads 0.
   function automatic logic [7:0] pins();
      return {out_a_oe, out_c_oe, out_b_oe, out_d_oe, gate};
   endfunction : pins

   function automatic logic [7:0] safe(input logic [1:0] ac, input logic [1:0] bd);
      logic oa;
      logic ob;
      oa = ~ac[1];
      ob = ~bd[1];
      return {oa, oa, ob, ob, oa & ac[0], oa & ac[0], ob & bd[0], ob & bd[0]};
   endfunction : safe

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
      wr(2'h0, 8'h7F);
      rd(2'h0, 8'h5F);
      wr(2'h3, 8'hFF);
      rd(2'h3, 8'h03);
      wr(2'h0, 8'h00);
      wr(2'h3, 8'h00);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_safe;
      logic [1:0] ac;
      logic [1:0] bd;
      logic [7:0] r;
      for (int i = 0; i < 4; i++) begin
         ac = 2'(i);
         bd = 2'(3 - i);
         r  = {4'h4, ac, bd};
         wr(2'h0, r);
         @(posedge sys_clk);
         int_req <= 1'b1;
         #2 chk(pins(), safe(ac, bd));
         rd(2'h0, r | 8'h80);
         wr(2'h0, r);
         rd(2'h0, r | 8'h80);
         chk(pins(), safe(ac, bd));
         @(posedge sys_clk);
         int_req <= 1'b0;
         rd(2'h0, r | 8'h80);
         wr(2'h0, r);
         rd(2'h0, r);
         chk(pins(), safe(ac, bd));
         pulse;
         chk(pins(), 8'hFC);
      end
      rd(2'h2, 8'h03);
      irqc(8'h00, 1'b0);
      irqc(8'h01, 1'b1);
      wr(2'h2, 8'h01);
      #1 chk({7'h00, irq}, 8'h00);
      rd(2'h2, 8'h02);
      irqc(8'h02, 1'b1);
      wr(2'h2, 8'h02);
      #1 chk({7'h00, irq}, 8'h00);
      $display("t_safe done");
   endtask : t_safe

   task automatic t_soft;
      wr(2'h0, 8'h81);
      #1 chk(pins(), safe(2'h0, 2'h1));
      rd(2'h0, 8'h81);
      wr(2'h0, 8'h01);
      pulse;
      chk(pins(), 8'hFC);
      wr(2'h2, 8'h03);
      $display("t_soft done");
   endtask : t_soft

   task automatic t_auto;
      wr(2'h1, 8'h80);
      rd(2'h1, 8'h80);
      wr(2'h0, 8'h00);
      @(posedge sys_clk);
      port_req <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 chk(pins(), 8'hFC);
      wr(2'h0, 8'h10);
      #1 chk(pins(), 8'hF0);
      repeat (4) @(posedge sys_clk);
      rd(2'h0, 8'h90);
      @(posedge sys_clk);
      port_req <= 1'b0;
      rd(2'h0, 8'h10);
      chk(pins(), 8'hF0);
      pulse;
      chk(pins(), 8'hFC);
      wr(2'h1, 8'h00);
      wr(2'h2, 8'h03);
      $display("t_auto done");
   endtask : t_auto

   // Measures the edges from a raw rising drive to the delayed pin.
   task automatic db_case(input bit s, input logic [7:0] ctl, input logic hb,
                          input int lo, input int hi);
      int k;
      wr(2'h1, ctl);
      @(posedge sys_clk);
      half_bridge <= hb;
      pwm_a       <= 1'b0;
      pwm_b       <= 1'b0;
      repeat (3) @(posedge sys_clk);
      if (s) pwm_b <= 1'b1;
      else pwm_a <= 1'b1;
      k = 0;
      while (((s ? out_b : out_a) !== 1'b1) && k < 600) begin
         @(posedge sys_clk);
         #1 k++;
      end
      chk({7'h00, k >= lo && k <= hi}, 8'h01);
      @(posedge sys_clk);
      pwm_a <= 1'b0;
      pwm_b <= 1'b0;
      @(posedge sys_clk);
      #1 chk({out_a, out_b}, 8'h00);
   endtask : db_case

   task automatic t_db;
      db_case(1'b0, 8'h05, 1'b1, 4 * 5 - 3, 4 * 5 + 2);
      db_case(1'b0, 8'h7F, 1'b1, 4 * 127 - 3, 4 * 127 + 2);
      db_case(1'b1, 8'h00, 1'b1, 1, 1);
      db_case(1'b0, 8'h05, 1'b0, 1, 1);
      $display("t_db done");
   endtask : t_db

   task automatic end_sim;
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      {rst_n, reg_wr, reg_rd, half_bridge, period_start, pwm_b} = '0;
      {int_req, port_req, reg_addr, reg_wdata} = '0;
      pwm_a = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 chk(pins(), 8'hF0);
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset;
      t_safe;
      t_soft;
      t_auto;
      t_db;
      end_sim;
   end

   // The whole run needs about 710 cycles; seventy times that means a hang.
   initial begin
      #500000;
      n_mismatch++;
      end_sim;
   end
endmodule : pwmsd_top_tb_top
